// [hdl/cwd_pkg.sv]
package cwd_pkg;
   // ***************************************************
   // Configuration word map
   // ***************************************************
   localparam int WORD_W = 14;
   localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
   localparam logic [13:0] CFG_ERASED = 14'h3fff;
   localparam logic [13:0] CFG_UNIMPL_MASK = 14'h3fa0;
   localparam int BIT_BROWNOUT = 6;
   localparam int BIT_CODEPROT = 4;
   localparam int BIT_TIMER_N = 3;
   localparam int BIT_WDOG = 2;
   localparam int BIT_OSC_HI = 1;
   localparam int BIT_OSC_LO = 0;
   // ***************************************************
   // AXI4-Lite register offsets (byte addresses)
   // ***************************************************
   localparam logic [15:0] OFS_CFG_WORD = 16'h2007 << 2;
   localparam logic [15:0] OFS_STATUS = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      CWD_OSC_LOW_PWR = 2'b00,
      CWD_OSC_CRYSTAL = 2'b01,
      CWD_OSC_HI_SPEED = 2'b10,
      CWD_OSC_RES_CAP = 2'b11
   } cwd_osc_mode_t;

   typedef struct packed
   {
      logic brownout_reset_enable_cfg;
      logic code_protect_cfg;
      logic powerup_timer_enable_n;
      logic watchdog_enable_cfg;
      cwd_osc_mode_t osc_mode;
   } cwd_settings_t;

   typedef struct packed
   {
      logic wr;
      logic [13:0] addr;
      logic [13:0] data;
   } cwd_prog_req_t;
endpackage

// [hdl/cwd_nvm_cell.sv]
`timescale 1ns/1ps
// Non-volatile word model: programming only clears bits, erase sets all.
module cwd_nvm_cell
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic prog_i,
   input wire logic erase_i,
   input wire logic [13:0] data_i,
   output logic [13:0] word_o
);
   logic [13:0] word;
   wire logic [13:0] next_word = erase_i ? cwd_pkg::CFG_ERASED
      : (prog_i ? (word & data_i) : word);

   // Content survives reset in silicon; here reset means erased state
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         word <= cwd_pkg::CFG_ERASED;
      else
         word <= next_word;
   end

   // Unimplemented positions are forced high on the read path
   assign word_o = word | cwd_pkg::CFG_UNIMPL_MASK;
endmodule

// [hdl/cwd_decode.sv]
`timescale 1ns/1ps
module cwd_decode
(
   input wire logic [13:0] word_i,
   output cwd_pkg::cwd_settings_t settings_o
);
   // Bit 4 and bit 3 are active low in the word
   assign settings_o.brownout_reset_enable_cfg =
      word_i[cwd_pkg::BIT_BROWNOUT];
   assign settings_o.code_protect_cfg =
      ~word_i[cwd_pkg::BIT_CODEPROT];
   assign settings_o.powerup_timer_enable_n =
      word_i[cwd_pkg::BIT_TIMER_N];
   assign settings_o.watchdog_enable_cfg =
      word_i[cwd_pkg::BIT_WDOG];
   assign settings_o.osc_mode = cwd_pkg::cwd_osc_mode_t'(
      word_i[cwd_pkg::BIT_OSC_HI:cwd_pkg::BIT_OSC_LO]);
endmodule

// [hdl/cwd_config_word_decoder.sv]
`timescale 1ns/1ps
// Summary of operation
// - Programmed bit reads zero, unprogrammed reads one
// - Word lives at program address 2007h
// - Programmer port access only in programming mode; AXI reads any time
// - Erased word reads 3FFFh
// - Bits 13-7 and 5 read one
// - Bits 1-0 select oscillator mode
module cwd_config_word_decoder
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Programmer port, already synchronous to ref_clk_i except the mode pin
   input wire logic prog_mode_i,
   input wire logic prog_valid_i,
   input wire logic prog_erase_i,
   input wire cwd_pkg::cwd_prog_req_t prog_req_i,
   output logic [13:0] prog_rdata_o,
   // Settings used by the rest of the chip
   output logic brownout_reset_enable_cfg_o,
   output logic code_protect_cfg_o,
   output logic powerup_timer_enable_n_o,
   output logic watchdog_enable_cfg_o,
   output logic [1:0] osc_mode_o,
   output logic low_power_crystal_mode_o,
   output logic crystal_resonator_mode_o,
   output logic high_speed_crystal_mode_o,
   output logic resistor_capacitor_osc_mode_o,
   // AXI4-Lite slave, read-only view
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ***************************************************
   // Programmer access
   // ***************************************************
   logic [13:0] word;
   cwd_pkg::cwd_settings_t live;
   cwd_pkg::cwd_settings_t latched;
   logic [1:0] mode_sync;

   // Programming mode pin crosses in through two flops
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         mode_sync <= 2'h0;
      else
         mode_sync <= {mode_sync[0], prog_mode_i};
   end

   wire logic in_prog = mode_sync[1];
   wire logic addr_hit = prog_req_i.addr == cwd_pkg::CFG_WORD_ADDR;
   wire logic wr_ok = in_prog & prog_valid_i & prog_req_i.wr
      & addr_hit;
   wire logic erase_ok = in_prog & prog_valid_i & prog_erase_i;
   wire logic [13:0] next_prog_rdata = (in_prog & addr_hit) ? word
      : 14'h0000;

   cwd_nvm_cell u_cell
   (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .prog_i(wr_ok),
      .erase_i(erase_ok),
      .data_i(prog_req_i.data),
      .word_o(word)
   );

   cwd_decode u_dec
   (
      .word_i(word),
      .settings_o(live)
   );

   // ***************************************************
   // Settings latch
   // ***************************************************
   // Settings freeze while in programming mode so a half-written word
   // never reaches the oscillator or reset logic
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         latched <= '{1'b1, 1'b0, 1'b1, 1'b1,
            cwd_pkg::CWD_OSC_RES_CAP};
         prog_rdata_o <= 14'h0000;
      end
      else
      begin
         if (!in_prog)
            latched <= live;
         prog_rdata_o <= next_prog_rdata;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         brownout_reset_enable_cfg_o <= 1'b1;
         code_protect_cfg_o <= 1'b0;
         powerup_timer_enable_n_o <= 1'b1;
         watchdog_enable_cfg_o <= 1'b1;
         osc_mode_o <= 2'h3;
         low_power_crystal_mode_o <= 1'b0;
         crystal_resonator_mode_o <= 1'b0;
         high_speed_crystal_mode_o <= 1'b0;
         resistor_capacitor_osc_mode_o <= 1'b1;
      end
      else
      begin
         brownout_reset_enable_cfg_o <= latched.brownout_reset_enable_cfg;
         code_protect_cfg_o <= latched.code_protect_cfg;
         powerup_timer_enable_n_o <= latched.powerup_timer_enable_n;
         watchdog_enable_cfg_o <= latched.watchdog_enable_cfg;
         osc_mode_o <= latched.osc_mode;
         low_power_crystal_mode_o <=
            latched.osc_mode == cwd_pkg::CWD_OSC_LOW_PWR;
         crystal_resonator_mode_o <=
            latched.osc_mode == cwd_pkg::CWD_OSC_CRYSTAL;
         high_speed_crystal_mode_o <=
            latched.osc_mode == cwd_pkg::CWD_OSC_HI_SPEED;
         resistor_capacitor_osc_mode_o <=
            latched.osc_mode == cwd_pkg::CWD_OSC_RES_CAP;
      end
   end

   // ***************************************************
   // AXI4-Lite slave
   // ***************************************************
   // Writes are refused: the running program may not alter the word
   logic aw_held;
   logic w_held;
   // No new write is taken while a response is still pending
   wire logic wr_both = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid)
      & ~s_axi_bvalid;
   wire logic next_bvalid = s_axi_bvalid ? ~s_axi_bready
      : (wr_both & ~s_axi_bvalid);
   wire logic rd_take = s_axi_arvalid & s_axi_arready;
   wire logic rd_cfg = s_axi_araddr == cwd_pkg::OFS_CFG_WORD;
   wire logic rd_stat = s_axi_araddr == cwd_pkg::OFS_STATUS;
   wire logic [31:0] next_rdata = rd_cfg ? {18'h00000, word}
      : (rd_stat ? {31'h00000000, in_prog} : 32'h00000000);
   wire logic [1:0] next_rresp = (rd_cfg | rd_stat) ? cwd_pkg::RESP_OKAY
      : cwd_pkg::RESP_SLVERR;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         aw_held <= wr_both ? 1'b0 : (aw_held | s_axi_awvalid);
         w_held <= wr_both ? 1'b0 : (w_held | s_axi_wvalid);
         s_axi_bvalid <= next_bvalid;
         if (wr_both)
            s_axi_bresp <= cwd_pkg::RESP_SLVERR;
      end
   end

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (rd_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // ***************************************************
   // Checks
   // ***************************************************
   unimpl_ones_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      prog_rdata_o == 14'h0000 || (prog_rdata_o & cwd_pkg::CFG_UNIMPL_MASK)
         == cwd_pkg::CFG_UNIMPL_MASK)
      else $error("Unimplemented word bit reads zero");

   run_no_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !in_prog |=> $stable(word))
      else $error("Word changed outside programming mode");

   prog_clears_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      wr_ok && !erase_ok |=> (word & ~$past(prog_req_i.data)
         & ~cwd_pkg::CFG_UNIMPL_MASK) == 14'h0000)
      else $error("Programmed bit did not read zero");

   erase_ones_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      erase_ok |=> word == cwd_pkg::CFG_ERASED)
      else $error("Erased word not all ones");

   addr_gate_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      in_prog && !addr_hit |=> prog_rdata_o == 14'h0000)
      else $error("Read answered at wrong address");

   osc_map_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !in_prog ##2 1 |-> osc_mode_o == $past(word[1:0], 2))
      else $error("Oscillator mode differs from word bits");

   protect_map_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !in_prog ##2 1 |-> code_protect_cfg_o == !$past(word[4], 2)
         && watchdog_enable_cfg_o == $past(word[2], 2))
      else $error("Protect or watchdog decode wrong");

   axi_wr_err_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_axi_bvalid |-> s_axi_bresp == cwd_pkg::RESP_SLVERR)
      else $error("Bus write not refused");
endmodule

// [bench/cwd_prog_model.sv]
`timescale 1ns/1ps
// *****
// Programmer model
// *****
module cwd_prog_model
(
   input wire logic ref_clk_i,
   output logic prog_mode_o,
   output logic prog_valid_o,
   output logic prog_erase_o,
   output cwd_pkg::cwd_prog_req_t prog_req_o
);
   initial
   begin
      prog_mode_o = 1'b0;
      prog_valid_o = 1'b0;
      prog_erase_o = 1'b0;
      prog_req_o = '0;
   end
   // Mode pin is synced inside; allow the lag before any request
   task automatic mode(input logic m);
      @(posedge ref_clk_i);
      prog_mode_o <= m;
      repeat (5) @(posedge ref_clk_i);
   endtask
   // Held until the next edge; back to back calls keep the strobe up
   task automatic op(input logic w, input logic e, input logic [13:0] a,
      input logic [13:0] d);
      @(posedge ref_clk_i);
      prog_valid_o <= 1'b1;
      prog_erase_o <= e;
      prog_req_o <= '{wr: w, addr: a, data: d};
   endtask
   // Released lines toggle so a stale value never looks valid
   task automatic done();
      @(posedge ref_clk_i);
      prog_valid_o <= 1'b0;
      prog_erase_o <= 1'b0;
      prog_req_o <= ~prog_req_o;
   endtask
endmodule

// [bench/cwd_config_word_decoder_tb.sv]
`timescale 1ns/1ps
module cwd_config_word_decoder_tb;
   typedef struct
   {
      logic [13:0] d;
      logic [13:0] w;
      logic [9:0] s;
   } cwd_row_t;
   localparam logic [13:0] A = cwd_pkg::CFG_WORD_ADDR;
   localparam logic [15:0] OW = cwd_pkg::OFS_CFG_WORD;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic prog_mode_i, prog_valid_i, prog_erase_i;
   cwd_pkg::cwd_prog_req_t prog_req_i;
   logic [13:0] prog_rdata_o;
   logic brownout_reset_enable_cfg_o, code_protect_cfg_o;
   logic powerup_timer_enable_n_o, watchdog_enable_cfg_o;
   logic [1:0] osc_mode_o;
   logic low_power_crystal_mode_o, crystal_resonator_mode_o;
   logic high_speed_crystal_mode_o, resistor_capacitor_osc_mode_o;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd;
   int n_fail = 0;
   int n_checks = 0;
   int i;
   wire logic [9:0] sets = {brownout_reset_enable_cfg_o, code_protect_cfg_o,
      powerup_timer_enable_n_o, watchdog_enable_cfg_o, osc_mode_o,
      low_power_crystal_mode_o, crystal_resonator_mode_o,
      high_speed_crystal_mode_o, resistor_capacitor_osc_mode_o};
   // Settings: brownout, protect, timer_n, watchdog, osc, one-hot modes
   cwd_row_t rows [4] = '{'{14'h0000, 14'h3fa0, 10'h108},
      '{14'h0049, 14'h3fe9, 10'h394}, '{14'h0056, 14'h3ff6, 10'h262},
      '{14'h3fff, 14'h3fff, 10'h2f1}};

   cwd_config_word_decoder dut (.*);
   cwd_prog_model pm (.ref_clk_i, .prog_mode_o(prog_mode_i),
      .prog_valid_o(prog_valid_i), .prog_erase_o(prog_erase_i),
      .prog_req_o(prog_req_i));

   always #25 ref_clk_i = ~ref_clk_i;

   // *****
   // Shared tasks
   // *****
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic tmo();
      if (i >= 50)
      begin
         n_fail++;
         give_verdict();
      end
   endtask
   // Handshakes are judged on the rising edge itself, before updates land
   task automatic axi_rd(input logic [15:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_i);
         if (s_axi_arready === 1'b1)
            break;
      end
      tmo();
      s_axi_arvalid <= 1'b0;
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_i);
         if (s_axi_rvalid === 1'b1)
            break;
      end
      tmo();
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic axi_wr(input logic [15:0] a);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50 && !(ta && tw); i++)
      begin
         @(posedge ref_clk_i);
         if (!ta && s_axi_awready === 1'b1)
         begin
            ta = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!tw && s_axi_wready === 1'b1)
         begin
            tw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (!(ta && tw))
         i = 50;
      tmo();
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_i);
         if (s_axi_bvalid === 1'b1)
            break;
      end
      tmo();
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic prd(input logic [13:0] a);
      pm.op(1'b0, 1'b0, a, 14'h0000);
      pm.done();
      #1;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      give_verdict();
   end

   // *****
   // Main sequence
   // *****
   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      #1 chk("erased settings", sets, 10'h2f1);
      pm.op(1'b1, 1'b0, A, 14'h0000);
      pm.done();
      prd(A);
      chk("rdata out of mode", prog_rdata_o, 14'h0000);
      axi_wr(OW);
      chk("bresp", rsp, cwd_pkg::RESP_SLVERR);
      axi_rd(OW);
      chk("word untouched", rd, 32'h3fff);
      axi_rd(16'h0010);
      chk("unmapped resp", rsp, cwd_pkg::RESP_SLVERR);
      pm.mode(1'b1);
      axi_rd(cwd_pkg::OFS_STATUS);
      chk("status", rd, 32'h1);
      prd(A - 14'h0001);
      chk("wrong address", prog_rdata_o, 14'h0000);
      foreach (rows[k])
      begin
         pm.op(1'b0, 1'b1, A, 14'h0000);
         pm.op(1'b1, 1'b0, A, rows[k].d);
         pm.done();
         prd(A);
         chk("prog read", prog_rdata_o, rows[k].w);
         pm.mode(1'b0);
         chk("settings", sets, rows[k].s);
         axi_rd(OW);
         chk("bus word", rd, {18'h0, rows[k].w});
         pm.mode(1'b1);
      end
      // Two programs in a row only clear bits; outputs hold in mode
      pm.op(1'b1, 1'b0, A, 14'h3ffe);
      pm.op(1'b1, 1'b0, A, 14'h3ffd);
      pm.done();
      prd(A);
      chk("and of writes", prog_rdata_o, 14'h3ffc);
      chk("frozen", sets, 10'h2f1);
      pm.mode(1'b0);
      chk("low power", sets, 10'h2c8);
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      #1 chk("reset again", sets, 10'h2f1);
      give_verdict();
   end
endmodule
